// ===== src/tcp_map.vh
/*
 * Constants of the timer channel compare and PWM block: register byte
 * addresses, field positions, reset values and channel mode codes.
 * Assumes it is included by bare name from the design files.
 */
`ifndef TCP_MAP_VH
`define TCP_MAP_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define TCP_OFS_CTRL      8'h00
`define TCP_OFS_MODULO    8'h04
`define TCP_OFS_INITIAL   8'h08
`define TCP_OFS_COUNT     8'h0c
`define TCP_OFS_CH0_CFG   8'h10
`define TCP_OFS_CH0_VAL   8'h14
`define TCP_OFS_CH1_CFG   8'h18
`define TCP_OFS_CH1_VAL   8'h1c
`define TCP_OFS_STATUS    8'h20

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define TCP_CTRL_RUN      0
`define TCP_CTRL_CENTER   1
`define TCP_CTRL_ADV      2
`define TCP_CTRL_JOIN     3
`define TCP_CTRL_DECAP    4
`define TCP_CTRL_W        5

// ----------------------------------------------------------------
// Channel configuration fields
// ----------------------------------------------------------------
`define TCP_CFG_ELS_LO    0
`define TCP_CFG_ELS_HI    1
`define TCP_CFG_MS_LO     2
`define TCP_CFG_MS_HI     3
`define TCP_CFG_IE        4
`define TCP_CFG_FLAG      5
`define TCP_CFG_W         5

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define TCP_STS_FLAG0     0
`define TCP_STS_FLAG1     1
`define TCP_STS_OUT0      2
`define TCP_STS_OUT1      3
`define TCP_STS_DOWN      4

// ----------------------------------------------------------------
// Reset values and counter limits
// ----------------------------------------------------------------
`define TCP_RST_CTRL      5'h00
`define TCP_RST_CFG       5'h00
`define TCP_RST_WORD      16'h0000
`define TCP_CNT_FULL      16'hffff
`define TCP_CNT_ONE       16'h0001

// ----------------------------------------------------------------
// Channel mode codes
// ----------------------------------------------------------------
`define TCP_MODE_NONE     3'h0
`define TCP_MODE_OC       3'h1
`define TCP_MODE_EDGE_ALIGNED_PWM     3'h2
`define TCP_MODE_CENTER_ALIGNED_PWM     3'h3
`define TCP_MODE_COMB_EV  3'h4
`define TCP_MODE_COMB_OD  3'h5

`endif

// ===== src/tcp_chan.v
/*
 * Combinational output and event logic of one timer channel.
 * Assumes the caller registers the results on the counter step and
 * hands in the counter value of that step with its direction.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tcp_map.vh"

module tcp_chan (
    input  wire [2:0]  i_mode,
    input  wire [1:0]  i_els,
    input  wire        i_tick,
    input  wire        i_reload,
    input  wire        i_step_down,
    input  wire [15:0] i_cnt_next,
    input  wire [15:0] i_val,
    input  wire [15:0] i_pval,
    input  wire [15:0] i_mod,
    input  wire [15:0] i_cntin,
    input  wire        i_out,
    output reg         o_hit,
    output reg         o_out_next,
    output reg         o_drive
);

    reg match;
    reg pmatch;
    reg on_lvl;
    reg zero;
    reg full;

    always @* begin
        match      = i_tick & (i_cnt_next == i_val);
        pmatch     = i_tick & (i_cnt_next == i_pval);
        // Active level: high for select 1:0, low for select X:1
        on_lvl     = ~i_els[0];
        zero       = 1'b0;
        full       = 1'b0;
        o_hit      = 1'b0;
        o_out_next = i_out;
        o_drive    = (i_els != 2'b00);
        case (i_mode)
            `TCP_MODE_OC: begin
                o_hit = match; // RULE3 RULE4
                if (match) begin
                    case (i_els) // RULE2
                        2'b01:   o_out_next = ~i_out;
                        2'b10:   o_out_next = 1'b0;
                        2'b11:   o_out_next = 1'b1;
                        default: o_out_next = i_out;
                    endcase
                end
            end
            `TCP_MODE_EDGE_ALIGNED_PWM: begin
                zero = (i_val == `TCP_RST_WORD); // RULE11
                full = (i_val > i_mod); // RULE11
                if (zero) begin
                    o_out_next = ~on_lvl;
                end else if (full) begin
                    o_out_next = on_lvl;
                end else begin
                    o_hit = match; // RULE7 RULE8
                    if (i_reload) begin
                        o_out_next = on_lvl; // RULE9 RULE10
                    end
                    if (match) begin
                        o_out_next = ~on_lvl; // RULE9 RULE10
                    end
                end
            end
            `TCP_MODE_CENTER_ALIGNED_PWM: begin
                zero = (i_val == `TCP_RST_WORD) | i_val[15]; // RULE17
                full = ~i_val[15] & (i_val >= i_mod)
                       & (i_mod != `TCP_RST_WORD); // RULE17
                if (zero) begin
                    o_out_next = ~on_lvl;
                end else if (full) begin
                    o_out_next = on_lvl;
                end else begin
                    o_hit = match; // RULE15 RULE8
                    if (match) begin
                        // Rising count ends the pulse, falling starts it
                        o_out_next = i_step_down ? on_lvl : ~on_lvl; // RULE16
                    end
                end
            end
            `TCP_MODE_COMB_EV: begin
                o_hit = match; // RULE21
                // Later events in one step win: start, even, odd
                if (i_tick & (i_cnt_next == i_cntin)) begin
                    o_out_next = ~on_lvl; // RULE22
                end
                if (match) begin
                    o_out_next = on_lvl; // RULE22
                end
                if (pmatch) begin
                    o_out_next = ~on_lvl; // RULE22
                end
            end
            `TCP_MODE_COMB_OD: begin
                o_hit   = match; // RULE21 RULE23
                o_drive = 1'b0;
            end
            default: begin
                o_drive = 1'b0;
            end
        endcase
        // Undriven pin keeps its level, so a later toggle starts from it
        if (~o_drive) begin
            o_out_next = i_out; // RULE4 RULE8
        end
    end

endmodule

`default_nettype wire

// ===== src/tcp_top.v
/*
 * Timer channel pair with output compare, edge-aligned PWM,
 * center-aligned PWM and combine mode, plus its 16-bit counter and a
 * plain register port. Assumes one clock, a bus master on the same
 * clock, and pads that honour the output enables.
 */
// Local design decisions: the address-and-strobe port and the register addresses.
// Overview of operation
// RULE1: Output compare needs capture, join, center off and mode 0:1.
// RULE2: Compare match sets, clears or toggles output; toggle starts from old level.
// RULE3: Compare match sets the flag; interrupt only with enable set.
// RULE4: Compare with select 0:0 sets flag, leaves output undriven.
// RULE5: Edge PWM needs capture, join, center off, high mode bit set.
// RULE6: Edge PWM period is modulo minus initial plus one; width value minus initial.
// RULE7: Edge PWM match sets the flag at pulse end.
// RULE8: Edge or center PWM with select 0:0 flags but does not drive.
// RULE9: Edge PWM 1:0 goes high at reload, low at match.
// RULE10: Edge PWM X:1 goes low at reload, high at match.
// RULE11: Edge PWM value zero gives 0%, above modulo 100%, no flag.
// RULE12: Center PWM whenever capture and join off and center select set.
// RULE13: Center PWM width and period are twice value and modulo.
// RULE14: Software keeps modulo within 1 to 7FFF for center PWM.
// RULE15: Center PWM flags every match, counting down and up.
// RULE16: Center 1:0 high at down match, low at up match; X:1 inverse.
// RULE17: Center value zero or negative 0%; at or above modulo 100%.
// RULE18: Software avoids center PWM with a free-running counter.
// RULE19: Pair joins when advanced features and join set, capture and center off.
// RULE20: Combine period is modulo minus initial plus one; width value difference.
// RULE21: Each joined channel flags and interrupts on its own match.
// RULE22: Combine 1:0 low at start and odd match, high at even match.
// RULE23: Odd channel edge selects have no effect in combine mode.
// RULE24: Software keeps the initial value zero outside combine mode.
`timescale 1ns/1ps
`default_nettype none
`include "tcp_map.vh"

module tcp_top (
    input  wire        i_clock,
    input  wire        i_sys_rst,
    input  wire        i_clk_en,
    input  wire [7:0]  i_addr,
    input  wire [15:0] i_wdata,
    input  wire        i_wr,
    input  wire        i_rd,
    output reg  [15:0] o_rdata,
    output reg  [1:0]  o_chan_out,
    output reg  [1:0]  o_chan_oe,
    output reg  [1:0]  o_chan_irq
);

    // ----------------------------------------------------------------
    // Mode decode
    // ----------------------------------------------------------------
    function [2:0] tcp_mode;
        input [`TCP_CTRL_W-1:0] ctrl;
        input [1:0]             ms;
        input                   odd;
        begin
            if (ctrl[`TCP_CTRL_DECAP]) begin
                tcp_mode = `TCP_MODE_NONE;
            end else if (ctrl[`TCP_CTRL_JOIN]) begin
                if (ctrl[`TCP_CTRL_ADV] & ~ctrl[`TCP_CTRL_CENTER]) begin
                    tcp_mode = odd ? `TCP_MODE_COMB_OD
                                   : `TCP_MODE_COMB_EV; // RULE19
                end else begin
                    tcp_mode = `TCP_MODE_NONE;
                end
            end else if (ctrl[`TCP_CTRL_CENTER]) begin
                tcp_mode = `TCP_MODE_CENTER_ALIGNED_PWM; // RULE12
            end else if (ms[1]) begin
                tcp_mode = `TCP_MODE_EDGE_ALIGNED_PWM; // RULE5
            end else if (ms == 2'b01) begin
                tcp_mode = `TCP_MODE_OC; // RULE1
            end else begin
                tcp_mode = `TCP_MODE_NONE;
            end
        end
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    reg [`TCP_CTRL_W-1:0] ctrl;
    reg [15:0]            modulo;
    reg [15:0]            initial_value;
    reg [15:0]            count;
    reg                   dir_down;
    reg [`TCP_CFG_W-1:0]  cfg0;
    reg [`TCP_CFG_W-1:0]  cfg1;
    reg [15:0]            val0;
    reg [15:0]            val1;
    reg [1:0]             flag;

    reg [15:0]            next_count;
    reg                   next_dir_down;
    reg                   reload;
    reg                   step_down;
    reg                   free_run;
    reg                   stalled;
    reg [15:0]            top;
    reg [1:0]             clr;
    reg [1:0]             next_flag;
    reg [15:0]            rd_word;

    wire                  run;
    wire                  tick;
    wire [2:0]            mode0;
    wire [2:0]            mode1;
    wire                  hit0;
    wire                  hit1;
    wire                  out0_next;
    wire                  out1_next;
    wire                  drive0;
    wire                  drive1;
    wire                  cnt_wr;

    assign run    = ctrl[`TCP_CTRL_RUN];
    assign cnt_wr = i_wr & (i_addr == `TCP_OFS_COUNT);
    assign tick   = run & ~stalled & ~cnt_wr;
    assign mode0  = tcp_mode(ctrl, {cfg0[`TCP_CFG_MS_HI], cfg0[`TCP_CFG_MS_LO]}, 1'b0);
    assign mode1  = tcp_mode(ctrl, {cfg1[`TCP_CFG_MS_HI], cfg1[`TCP_CFG_MS_LO]}, 1'b1);

    // ----------------------------------------------------------------
    // Counter
    // ----------------------------------------------------------------
    always @* begin
        // Free-running wrap ignores the modulo; center mode must avoid it
        free_run = (~ctrl[`TCP_CTRL_ADV] & ((modulo == `TCP_RST_WORD)
                    | (modulo == `TCP_CNT_FULL)))
                 | (ctrl[`TCP_CTRL_ADV] & ~ctrl[`TCP_CTRL_CENTER]
                    & (initial_value == `TCP_RST_WORD)
                    & (modulo == `TCP_CNT_FULL));
        // Advanced counter holds its count until a limit is written
        stalled  = ctrl[`TCP_CTRL_ADV] & (modulo == `TCP_RST_WORD)
                 & (initial_value == `TCP_RST_WORD);
        top      = free_run ? `TCP_CNT_FULL : modulo;
        next_count    = count;
        next_dir_down = dir_down;
        reload        = 1'b0;
        step_down     = 1'b0;
        if (cnt_wr) begin
            next_count    = initial_value;
            next_dir_down = 1'b0;
        end else if (tick) begin
            if (ctrl[`TCP_CTRL_CENTER]) begin
                // Up to the modulo, back down to the initial value
                if (~dir_down) begin
                    if (count == modulo) begin
                        next_count    = count - `TCP_CNT_ONE; // RULE13
                        next_dir_down = 1'b1;
                        step_down     = 1'b1;
                    end else begin
                        next_count = count + `TCP_CNT_ONE;
                    end
                end else begin
                    if (count == initial_value) begin
                        next_count    = count + `TCP_CNT_ONE; // RULE13
                        next_dir_down = 1'b0;
                    end else begin
                        next_count = count - `TCP_CNT_ONE;
                        step_down  = 1'b1;
                    end
                end
            end else begin
                if (count == top) begin
                    next_count = initial_value; // RULE6 RULE20
                    reload     = 1'b1;
                end else begin
                    next_count = count + `TCP_CNT_ONE;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Channels
    // ----------------------------------------------------------------
    tcp_chan u_chan0 (
        .i_mode      (mode0),
        .i_els       ({cfg0[`TCP_CFG_ELS_HI], cfg0[`TCP_CFG_ELS_LO]}),
        .i_tick      (tick),
        .i_reload    (reload),
        .i_step_down (step_down),
        .i_cnt_next  (next_count),
        .i_val       (val0),
        .i_pval      (val1),
        .i_mod       (modulo),
        .i_cntin     (initial_value),
        .i_out       (o_chan_out[0]),
        .o_hit       (hit0),
        .o_out_next  (out0_next),
        .o_drive     (drive0)
    );

    tcp_chan u_chan1 (
        .i_mode      (mode1),
        .i_els       ({cfg1[`TCP_CFG_ELS_HI], cfg1[`TCP_CFG_ELS_LO]}),
        .i_tick      (tick),
        .i_reload    (reload),
        .i_step_down (step_down),
        .i_cnt_next  (next_count),
        .i_val       (val1),
        .i_pval      (val0),
        .i_mod       (modulo),
        .i_cntin     (initial_value),
        .i_out       (o_chan_out[1]),
        .o_hit       (hit1),
        .o_out_next  (out1_next),
        .o_drive     (drive1)
    );

    // ----------------------------------------------------------------
    // Event flags
    // ----------------------------------------------------------------
    always @* begin
        // Writing 1 to the flag bit clears it; a same-cycle match wins
        clr[0] = i_wr & (i_addr == `TCP_OFS_CH0_CFG) & i_wdata[`TCP_CFG_FLAG];
        clr[1] = i_wr & (i_addr == `TCP_OFS_CH1_CFG) & i_wdata[`TCP_CFG_FLAG];
        next_flag = (flag & ~clr) | {hit1, hit0}; // RULE3 RULE21
    end

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    always @* begin
        rd_word = `TCP_RST_WORD;
        case (i_addr)
            `TCP_OFS_CTRL:    rd_word = {11'h000, ctrl};
            `TCP_OFS_MODULO:  rd_word = modulo;
            `TCP_OFS_INITIAL: rd_word = initial_value;
            `TCP_OFS_COUNT:   rd_word = count;
            `TCP_OFS_CH0_CFG: rd_word = {10'h000, flag[0], cfg0};
            `TCP_OFS_CH0_VAL: rd_word = val0;
            `TCP_OFS_CH1_CFG: rd_word = {10'h000, flag[1], cfg1};
            `TCP_OFS_CH1_VAL: rd_word = val1;
            `TCP_OFS_STATUS:  rd_word = {11'h000, dir_down, o_chan_out, flag};
            default:          rd_word = `TCP_RST_WORD;
        endcase
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ctrl          <= `TCP_RST_CTRL;
            modulo        <= `TCP_RST_WORD;
            initial_value <= `TCP_RST_WORD;
            count         <= `TCP_RST_WORD;
            dir_down      <= 1'b0;
            cfg0          <= `TCP_RST_CFG;
            cfg1          <= `TCP_RST_CFG;
            val0          <= `TCP_RST_WORD;
            val1          <= `TCP_RST_WORD;
            flag          <= 2'h0;
            o_rdata       <= `TCP_RST_WORD;
            o_chan_out    <= 2'h0;
            o_chan_oe     <= 2'h0;
            o_chan_irq    <= 2'h0;
        end else if (i_clk_en) begin
            count    <= next_count;
            dir_down <= next_dir_down;
            flag     <= next_flag;
            // Interrupt is the flag gated by its enable
            o_chan_irq[0] <= next_flag[0] & cfg0[`TCP_CFG_IE]; // RULE3 RULE21
            o_chan_irq[1] <= next_flag[1] & cfg1[`TCP_CFG_IE]; // RULE21
            // Undriven channels keep their level for a later toggle start
            o_chan_out <= {out1_next, out0_next}; // RULE2
            o_chan_oe  <= {drive1, drive0}; // RULE4 RULE8 RULE23
            o_rdata    <= i_rd ? rd_word : `TCP_RST_WORD;
            if (i_wr) begin
                case (i_addr)
                    `TCP_OFS_CTRL:    ctrl <= i_wdata[`TCP_CTRL_W-1:0];
                    `TCP_OFS_MODULO:  modulo <= i_wdata;
                    `TCP_OFS_INITIAL: initial_value <= i_wdata;
                    `TCP_OFS_CH0_CFG: cfg0 <= i_wdata[`TCP_CFG_W-1:0];
                    `TCP_OFS_CH0_VAL: val0 <= i_wdata;
                    `TCP_OFS_CH1_CFG: cfg1 <= i_wdata[`TCP_CFG_W-1:0];
                    `TCP_OFS_CH1_VAL: val1 <= i_wdata;
                    default:          ctrl <= ctrl;
                endcase
            end
        end
    end

endmodule

`default_nettype wire

// ===== tb/tcp_top_checker.sv
/* Port-level checks of the timer channel pair.
   Assumes it is bound into tcp_top and shares its one clock and reset. */
`timescale 1ns/1ps
`default_nettype none
`include "tcp_map.vh"

module tcp_top_checker (
    input wire logic        i_clock,
    input wire logic        i_sys_rst,
    input wire logic        i_clk_en,
    input wire logic [7:0]  i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [15:0] o_rdata,
    input wire logic [1:0]  o_chan_out,
    input wire logic [1:0]  o_chan_oe,
    input wire logic [1:0]  o_chan_irq
);
    // ------------------------------------------------------------
    // Shadow of what software wrote
    // ------------------------------------------------------------
    logic [4:0] ctrl;
    logic [4:0] cfg0;
    wire        unmapped = (i_addr > 8'h20) || (i_addr[1:0] != 2'h0);
    wire        comb = ctrl[`TCP_CTRL_ADV] && ctrl[`TCP_CTRL_JOIN]
                       && !ctrl[`TCP_CTRL_DECAP] && !ctrl[`TCP_CTRL_CENTER];
    wire        epwm0 = !ctrl[`TCP_CTRL_CENTER] && !ctrl[`TCP_CTRL_JOIN]
                        && !ctrl[`TCP_CTRL_DECAP] && cfg0[`TCP_CFG_MS_HI]
                        && (cfg0[1:0] != 2'h0);

    // Writes lost while the clock enable is low must not move the shadow
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ctrl <= 5'h00;
            cfg0 <= 5'h00;
        end else if (i_clk_en && i_wr) begin
            if (i_addr == `TCP_OFS_CTRL) ctrl <= i_wdata[4:0];
            if (i_addr == `TCP_OFS_CH0_CFG) cfg0 <= i_wdata[4:0];
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);

    a_rdata_idle: assert property ($past(i_clk_en) && !$past(i_rd) |-> o_rdata == 16'h0000)
        else $error("read data not idle");
    a_unmapped_zero: assert property ($past(i_clk_en) && $past(i_rd) && $past(unmapped)
        |-> o_rdata == 16'h0000) else $error("unmapped read not zero");
    a_irq_flag0: assert property ($past(i_clk_en) && $past(i_rd)
        && $past(i_addr) == `TCP_OFS_CH0_CFG |-> (o_rdata[5] && o_rdata[4]) == $past(o_chan_irq[0]))
        else $error("even irq disagrees with flag and enable");
    a_irq_flag1: assert property ($past(i_clk_en) && $past(i_rd)
        && $past(i_addr) == `TCP_OFS_CH1_CFG |-> (o_rdata[5] && o_rdata[4]) == $past(o_chan_irq[1]))
        else $error("odd irq disagrees with flag and enable");
    a_irq_needs_ie: assert property ($rose(o_chan_irq[0]) |-> cfg0[`TCP_CFG_IE])
        else $error("irq raised without enable");
    a_noels_oe: assert property (cfg0[1:0] == 2'h0 && $past(cfg0[1:0]) == 2'h0
        |-> !o_chan_oe[0]) else $error("pin driven with select 0:0");
    a_edge_aligned_pwm_oe: assert property (epwm0 && $past(epwm0) |-> o_chan_oe[0])
        else $error("edge pwm pin not driven");
    a_odd_quiet: assert property (comb && $past(comb) |-> !o_chan_oe[1])
        else $error("odd pin driven in combine mode");
    a_freeze_hold: assert property (!$past(i_clk_en) |-> $stable(o_chan_out) && $stable(o_chan_irq))
        else $error("outputs moved while frozen");
endmodule

bind tcp_top tcp_top_checker u_chk (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_chan_out(o_chan_out), .o_chan_oe(o_chan_oe), .o_chan_irq(o_chan_irq)
);
`default_nettype wire

// ===== tb/tcp_top_tb.sv
/* Self-checking bench of the timer channel pair: register port tasks,
   pulse measurement on the channel 0 pin. Assumes a 10 MHz clock, no far-side model. */
`timescale 1ns/1ps
`default_nettype none
`include "tcp_map.vh"

module tcp_top_tb;
    logic        i_clock;
    logic        i_sys_rst;
    logic        i_clk_en;
    logic [7:0]  i_addr;
    logic [15:0] i_wdata;
    logic        i_wr;
    logic        i_rd;
    wire  [15:0] o_rdata;
    wire  [1:0]  o_chan_out;
    wire  [1:0]  o_chan_oe;
    wire  [1:0]  o_chan_irq;
    logic [15:0] rv;
    int          mismatches;
    int          comparisons;
    logic [7:0]  zregs [8] = '{`TCP_OFS_CTRL, `TCP_OFS_MODULO, `TCP_OFS_COUNT,
        `TCP_OFS_CH0_CFG, `TCP_OFS_CH1_VAL, `TCP_OFS_STATUS, 8'h24, 8'h02};

    tcp_top u_tcp_top (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_chan_out(o_chan_out), .o_chan_oe(o_chan_oe), .o_chan_irq(o_chan_irq));

    initial begin
        i_clock = 1'b0;
        forever #50 i_clock = ~i_clock;
    end

    // ------------------------------------------------------------
    // Bus, compare and measurement tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_clock);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_clock);
        i_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge i_clock);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_clock);
        i_rd   <= 1'b0;
        @(negedge i_clock);
        rv = o_rdata;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Bounded wait, so a stuck pin reads as a huge count
    task automatic edge_wait(input logic lvl, output logic [15:0] n);
        n = 16'h0000;
        while (o_chan_out[0] !== lvl && n < 16'd200) begin
            @(negedge i_clock);
            n++;
        end
    endtask

    task automatic pwm(input logic [15:0] cfg, val, ehi, elo);
        logic [15:0] n;
        logic [15:0] hi;
        logic [15:0] lo;
        wr(`TCP_OFS_CH0_VAL, val);
        wr(`TCP_OFS_CH0_CFG, cfg);
        repeat (16) @(negedge i_clock);
        edge_wait(1'b0, n);
        edge_wait(1'b1, n);
        edge_wait(1'b0, hi);
        edge_wait(1'b1, lo);
        chk(hi, ehi);
        chk(lo, elo);
    endtask

    // Flag cleared with the config write; pin lags the config by a step
    // and an output compare level waits for its first match
    task automatic flat(input logic [15:0] cfg, val, input logic lvl, flg, eoe);
        wr(`TCP_OFS_CH0_VAL, val);
        wr(`TCP_OFS_CH0_CFG, cfg | 16'h0020);
        repeat (8) @(negedge i_clock);
        repeat (16) begin
            @(negedge i_clock);
            chk(o_chan_out[0], lvl);
        end
        chk(o_chan_oe[0], eoe);
        rd(`TCP_OFS_CH0_CFG);
        chk(rv[5], flg);
    endtask

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge i_clock);
        mismatches++;
        wrap_up;
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        i_sys_rst   = 1'b1;
        i_clk_en    = 1'b1;
        i_addr      = 8'h00;
        i_wdata     = 16'h0000;
        i_wr        = 1'b0;
        i_rd        = 1'b0;
        mismatches  = 0;
        comparisons = 0;
        repeat (8) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        wr(8'h24, 16'hffff);
        foreach (zregs[k]) begin
            rd(zregs[k]);
            chk(rv, 16'h0000);
        end
        chk(o_chan_oe, 2'h0);
        wr(`TCP_OFS_MODULO, 16'h0004);
        wr(`TCP_OFS_CTRL, 16'h0001);
        pwm(16'h001a, 16'h0002, 16'h0002, 16'h0003);
        chk(o_chan_irq[0], 1'b1);
        pwm(16'h0019, 16'h0002, 16'h0003, 16'h0002);
        wr(`TCP_OFS_CH0_CFG, 16'h0029);
        repeat (2) @(negedge i_clock);
        chk(o_chan_irq[0], 1'b0);
        flat(16'h000a, 16'h0005, 1'b1, 1'b0, 1'b1);
        flat(16'h000a, 16'h0000, 1'b0, 1'b0, 1'b1);
        flat(16'h0008, 16'h0002, 1'b0, 1'b1, 1'b0);
        flat(16'h0007, 16'h0002, 1'b1, 1'b1, 1'b1);
        flat(16'h0006, 16'h0002, 1'b0, 1'b1, 1'b1);
        flat(16'h0004, 16'h0002, 1'b0, 1'b1, 1'b0);
        pwm(16'h0005, 16'h0002, 16'h0005, 16'h0005);
        wr(`TCP_OFS_CTRL, 16'h0003);
        pwm(16'h001a, 16'h0001, 16'h0002, 16'h0006);
        chk(o_chan_irq[0], 1'b1);
        pwm(16'h0009, 16'h0001, 16'h0006, 16'h0002);
        flat(16'h000a, 16'h0000, 1'b0, 1'b0, 1'b1);
        flat(16'h000a, 16'h8000, 1'b0, 1'b0, 1'b1);
        flat(16'h000a, 16'h0004, 1'b1, 1'b0, 1'b1);
        wr(`TCP_OFS_CH1_VAL, 16'h0003);
        wr(`TCP_OFS_CH1_CFG, 16'h0013);
        wr(`TCP_OFS_CTRL, 16'h000d);
        pwm(16'h0012, 16'h0001, 16'h0002, 16'h0003);
        chk(o_chan_irq, 2'h3);
        rd(`TCP_OFS_CH1_CFG);
        chk(rv[5:4], 2'h3);
        wr(`TCP_OFS_CH1_CFG, 16'h0010);
        pwm(16'h0012, 16'h0001, 16'h0002, 16'h0003);
        pwm(16'h0011, 16'h0001, 16'h0003, 16'h0002);
        @(posedge i_clock);
        i_clk_en <= 1'b0;
        @(negedge i_clock);
        rv = {14'h0000, o_chan_out};
        repeat (10) begin
            @(negedge i_clock);
            chk(o_chan_out, rv[1:0]);
        end
        @(posedge i_clock);
        i_clk_en <= 1'b1;
        wrap_up;
    end
endmodule
`default_nettype wire
